// ---- tx_cond_pkg.sv ----
// constants for the transmit timeslot conditioning block
package tx_cond_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the AXI4-Lite slave)
    // ------------------------------------------------------------
    localparam logic [7:0] CHAN_CTRL_BASE = 8'h00;   // 32 words 0x00..0x7C
    localparam logic [7:0] USER_IDLE_ADDR = 8'h80;
    localparam logic [7:0] DL_SELECT_ADDR = 8'h84;
    localparam logic [7:0] MODE_ADDR = 8'h88;
    localparam int NUM_SLOTS = 32;
    localparam int SLOT_W = 5;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CHAN_CTRL_RESET = 8'h80;
    localparam logic [7:0] USER_IDLE_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int LAPD_HI = 7;
    localparam int LAPD_LO = 6;
    localparam int ZCS_HI = 5;
    localparam int ZCS_LO = 4;
    localparam int COND_HI = 3;
    localparam int COND_LO = 0;
    localparam logic [1:0] LAPD_FIRST = 2'h0;
    localparam logic [1:0] LAPD_SECOND = 2'h1;
    localparam logic [1:0] LAPD_DLSEL = 2'h2;
    localparam logic [1:0] LAPD_THIRD = 2'h3;
    localparam logic [1:0] ZCS_NONE = 2'h0;
    localparam logic [1:0] ZCS_BIT7 = 2'h1;
    localparam logic [1:0] ZCS_ALT = 2'h2;
    localparam logic [1:0] ZCS_DDS = 2'h3;
    // ------------------------------------------------------------
    // conditioning codes and fixed octets
    // ------------------------------------------------------------
    localparam logic [3:0] C_PASS = 4'h0;
    localparam logic [3:0] C_INV_ALL = 4'h1;
    localparam logic [3:0] C_INV_EVEN = 4'h2;
    localparam logic [3:0] C_INV_ODD = 4'h3;
    localparam logic [3:0] C_USER_IDLE = 4'h4;
    localparam logic [3:0] C_BUSY = 4'h5;
    localparam logic [3:0] C_VACANT = 4'h6;
    localparam logic [3:0] C_BUSY_TIMESLOT_CODE = 4'h7;
    localparam logic [3:0] C_MUX_OUT_OF_FRAME_CODE = 4'h8;
    localparam logic [3:0] C_MW_ALAW = 4'h9;
    localparam logic [3:0] C_MW_ULAW = 4'hA;
    localparam logic [3:0] C_INV_MSB = 4'hB;
    localparam logic [3:0] C_INV_LOW = 4'hC;
    localparam logic [3:0] C_PRBS = 4'hD;
    localparam logic [3:0] C_PASS2 = 4'hE;
    localparam logic [3:0] C_DE_SLOT = 4'hF;
    localparam logic [7:0] EVEN_MASK = 8'h55;
    localparam logic [7:0] ODD_MASK = 8'hAA;
    localparam logic [7:0] MSB_MASK = 8'h80;
    localparam logic [7:0] LOW_MASK = 8'h7F;
    localparam logic [7:0] ALL_MASK = 8'hFF;
    localparam logic [7:0] BUSY_CODE = 8'h7F;
    localparam logic [7:0] VACANT_CODE = 8'hFF;
    localparam logic [7:0] busy_timeslot_code = 8'hE0;
    localparam logic [7:0] mux_out_of_frame_code = 8'h1A;
    localparam logic [7:0] BIT7_FORCE = 8'h02;
    localparam logic [7:0] ALT_ZCS_CODE = 8'hDE;
    localparam logic [7:0] DDS_ZCS_CODE = 8'h98;
    localparam logic [7:0] ZERO_OCTET = 8'h00;
    localparam logic [8:0] PRBS_SEED = 9'h1FF;
    // one cycle of the 1 kHz tone is eight samples at 8 kHz
    localparam logic [2:0] MW_LAST = 3'h7;
endpackage : tx_cond_pkg

// ---- tx_timeslot_conditioning.sv ----
// transmit per-timeslot conditioning with AXI4-Lite register access
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - one 8-bit control word per timeslot 0..31
// - source 00 takes first LAPD controller
// - source 01 takes second LAPD controller
// - source 11 takes third LAPD controller
// - source 10 in T1 uses 2-bit selector
// - source 10 in E1 uses 3-bit selector
// - T1 suppression 00 leaves octet unchanged
// - suppression 01 applies bit-7 stuffing
// - 10 alternate scheme, 11 data-service scheme
// - codes 0000 and 1110 pass octet through
// - invert all, even or odd bits
// - invert MSB only, or all but MSB
// - code 0100 sends user idle octet
// - busy 0x7F, vacant 0xFF replacement
// - busy timeslot pattern 111xxxxx
// - mux out-of-frame code 0x1A
// - A-law or u-law milliwatt sequence
// - code 1101 sends PRBS generator output
// - code 1111 marks the signalling timeslot
// - user idle code is 8-bit read/write
module tx_timeslot_conditioning
    import tx_cond_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic pcmValid,
    input wire logic [SLOT_W-1:0] pcmSlot,
    input wire logic [7:0] pcmIn,
    input wire logic [7:0] lapd1Data,
    input wire logic [7:0] lapd2Data,
    input wire logic [7:0] lapd3Data,
    input wire logic [7:0] dlSrcData [0:7],
    output logic lineValid,
    output logic [SLOT_W-1:0] lineSlot,
    output logic [7:0] lineData,
    output logic lineDeSlot
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        W_IDLE = 3'b001,
        W_RESP = 3'b010,
        W_HOLD = 3'b100
    } wr_state_t;

    logic [7:0] chanCtrl_q [0:NUM_SLOTS-1];
    logic [7:0] userIdle_q;
    logic [2:0] dlSel_q;
    logic e1Mode_q;
    wr_state_t wrState_q;
    logic awHave_q;
    logic wHave_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic [8:0] prbs_q;
    logic [2:0] mwIdx_q;
    logic [7:0] cond_d;
    logic de_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic isChan(input logic [ADDR_W-1:0] a);
        isChan = (a[ADDR_W-1] == CHAN_CTRL_BASE[ADDR_W-1]);
    endfunction : isChan

    function automatic logic [SLOT_W-1:0] slotOf(
        input logic [ADDR_W-1:0] a);
        slotOf = a[SLOT_W+1:2];
    endfunction : slotOf

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = isChan(a) || a == USER_IDLE_ADDR ||
            a == DL_SELECT_ADDR || a == MODE_ADDR;
    endfunction : mapped

    // milliwatt sample tables, one tone period each
    function automatic logic [7:0] mwSample(input logic alaw,
        input logic [2:0] i);
        logic [7:0] a;
        logic [7:0] u;
        a = 8'h00;
        u = 8'h00;
        case (i)
            3'h0: begin a = 8'h34; u = 8'h1E; end
            3'h1: begin a = 8'h21; u = 8'h0B; end
            3'h2: begin a = 8'h21; u = 8'h0B; end
            3'h3: begin a = 8'h34; u = 8'h1E; end
            3'h4: begin a = 8'hB4; u = 8'h9E; end
            3'h5: begin a = 8'hA1; u = 8'h8B; end
            3'h6: begin a = 8'hA1; u = 8'h8B; end
            default: begin a = 8'hB4; u = 8'h9E; end
        endcase
        mwSample = alaw ? a : u;
    endfunction : mwSample

    function automatic logic [7:0] laneMerge(input logic [7:0] old,
        input logic [31:0] d, input logic [3:0] s);
        laneMerge = s[0] ? d[7:0] : old;
    endfunction : laneMerge

    // eight generator steps per octet, applied in one clock
    function automatic logic [8:0] prbsStep8(input logic [8:0] p);
        prbsStep8 = p;
        for (int k = 0; k < 8; k++)
            prbsStep8 = {prbsStep8[7:0], prbsStep8[8] ^ prbsStep8[4]};
    endfunction : prbsStep8

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    wire logic doWrite = awHave_q && wHave_q && wrState_q == W_IDLE;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            wrState_q <= W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (clkEn)
        begin
            // address and data accepted in either order
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            case (wrState_q)
                W_IDLE:
                    if (doWrite)
                    begin
                        awHave_q <= 1'b0;
                        wHave_q <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= mapped(awAddr_q) ? RESP_OKAY
                            : RESP_SLVERR;
                        wrState_q <= W_RESP;
                    end
                W_RESP:
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        wrState_q <= W_HOLD;
                    end
                W_HOLD:
                    wrState_q <= W_IDLE;
                default:
                    wrState_q <= W_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (clkEn)
        begin
            // ready only while the holding slot is empty
            s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready)
                && wrState_q == W_IDLE;
            s_axi_wready <= !wHave_q && !(s_axi_wvalid && s_axi_wready)
                && wrState_q == W_IDLE;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                chanCtrl_q[i] <= CHAN_CTRL_RESET;
            userIdle_q <= USER_IDLE_RESET;
            dlSel_q <= '0;
            e1Mode_q <= 1'b0;
        end
        else if (clkEn && doWrite)
        begin
            if (isChan(awAddr_q))
                chanCtrl_q[slotOf(awAddr_q)] <= laneMerge(
                    chanCtrl_q[slotOf(awAddr_q)], wData_q, wStrb_q);
            else if (awAddr_q == USER_IDLE_ADDR)
                userIdle_q <= laneMerge(userIdle_q, wData_q, wStrb_q);
            else if (awAddr_q == DL_SELECT_ADDR && wStrb_q[0])
                dlSel_q <= wData_q[2:0];
            else if (awAddr_q == MODE_ADDR && wStrb_q[0])
                e1Mode_q <= wData_q[0];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (clkEn)
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY
                    : RESP_SLVERR;
                if (isChan(s_axi_araddr))
                    s_axi_rdata <= {24'h0, chanCtrl_q[slotOf(s_axi_araddr)]};
                else if (s_axi_araddr == USER_IDLE_ADDR)
                    s_axi_rdata <= {24'h0, userIdle_q};
                else if (s_axi_araddr == DL_SELECT_ADDR)
                    s_axi_rdata <= {29'h0, dlSel_q};
                else if (s_axi_araddr == MODE_ADDR)
                    s_axi_rdata <= {31'h0, e1Mode_q};
                else
                    s_axi_rdata <= '0;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // octet conditioning
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] w;
        logic [7:0] o;
        logic [7:0] dl;
        w = chanCtrl_q[pcmSlot];
        o = pcmIn;
        de_d = 1'b0;
        // selector wider in E1; T1 uses the low two bits only
        dl = e1Mode_q ? dlSrcData[dlSel_q]
            : dlSrcData[{1'b0, dlSel_q[1:0]}];
        case (w[COND_HI:COND_LO])
            C_PASS, C_PASS2: o = pcmIn;
            C_INV_ALL: o = pcmIn ^ ALL_MASK;
            C_INV_EVEN: o = pcmIn ^ EVEN_MASK;
            C_INV_ODD: o = pcmIn ^ ODD_MASK;
            C_INV_MSB: o = pcmIn ^ MSB_MASK;
            C_INV_LOW: o = pcmIn ^ LOW_MASK;
            C_USER_IDLE: o = userIdle_q;
            C_BUSY: o = BUSY_CODE;
            C_VACANT: o = VACANT_CODE;
            // low five bits free; the line keeps them from input
            C_BUSY_TIMESLOT_CODE: o = busy_timeslot_code | pcmIn;
            C_MUX_OUT_OF_FRAME_CODE: o = mux_out_of_frame_code;
            C_MW_ALAW: o = mwSample(1'b1, mwIdx_q);
            C_MW_ULAW: o = mwSample(1'b0, mwIdx_q);
            C_PRBS: o = prbs_q[7:0];
            C_DE_SLOT:
            begin
                de_d = 1'b1;
                case (w[LAPD_HI:LAPD_LO])
                    LAPD_FIRST: o = lapd1Data;
                    LAPD_SECOND: o = lapd2Data;
                    LAPD_THIRD: o = lapd3Data;
                    default: o = dl;
                endcase
            end
            default: o = pcmIn;
        endcase
        // zero-code suppression, T1 only, on voice conditioning
        if (!e1Mode_q && !de_d && o == ZERO_OCTET)
        begin
            case (w[ZCS_HI:ZCS_LO])
                ZCS_NONE: o = o;
                ZCS_BIT7: o = o | BIT7_FORCE;
                ZCS_ALT: o = ALT_ZCS_CODE;
                ZCS_DDS: o = DDS_ZCS_CODE;
                default: o = o;
            endcase
        end
        cond_d = o;
    end

    // ------------------------------------------------------------
    // pattern generators and line output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prbs_q <= PRBS_SEED;
            mwIdx_q <= '0;
        end
        else if (clkEn && pcmValid)
        begin
            // x^9+x^5+1, stepped eight bits per octet
            prbs_q <= prbsStep8(prbs_q);
            // tone advances once per frame, at slot 0
            if (pcmSlot == '0)
                mwIdx_q <= (mwIdx_q == MW_LAST) ? '0 : mwIdx_q + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lineValid <= 1'b0;
            lineSlot <= '0;
            lineData <= '0;
            lineDeSlot <= 1'b0;
        end
        else if (clkEn)
        begin
            lineValid <= pcmValid;
            if (pcmValid)
            begin
                lineSlot <= pcmSlot;
                lineData <= cond_d;
                lineDeSlot <= de_d;
            end
        end
    end
endmodule : tx_timeslot_conditioning

// ---- tx_cond_props.sv ----
// port assertions for the timeslot conditioning block
`timescale 1ns/1ps
module tx_cond_props
    import tx_cond_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic pcmValid,
    input wire logic [SLOT_W-1:0] pcmSlot,
    input wire logic lineValid,
    input wire logic [SLOT_W-1:0] lineSlot,
    input wire logic [7:0] lineData
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic badAw_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            badAw_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
            badAw_q <= (s_axi_awaddr > MODE_ADDR);
    end
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    line_valid_a: assert property (
        clkEn && pcmValid |=> lineValid && lineSlot == $past(pcmSlot))
        else $error("octet missing or wrong slot");
    line_idle_a: assert property (
        clkEn && !pcmValid |=> !lineValid)
        else $error("octet without input");
    line_hold_a: assert property (
        clkEn && !pcmValid |=> $stable(lineData) && $stable(lineSlot))
        else $error("line output moved while idle");
    write_resp_a: assert property (
        wrTake |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    write_code_a: assert property (
        s_axi_bvalid |-> s_axi_bresp == (badAw_q ? RESP_SLVERR : RESP_OKAY))
        else $error("wrong write response code");
    read_resp_a: assert property (
        rdTake |=> s_axi_rvalid)
        else $error("read response late");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bad_read_a: assert property (
        rdTake ##0 (s_axi_araddr > MODE_ADDR) |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    read_width_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule : tx_cond_props

// ---- tx_pcm_partner.sv ----
// backplane octet and signalling source for the bench
`timescale 1ns/1ps
module tx_pcm_partner
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic slow,
    input wire logic [31:0] rnd,
    output logic pcmValid,
    output logic [4:0] pcmSlot,
    output logic [7:0] pcmIn,
    output logic [7:0] lapd1Data,
    output logic [7:0] lapd2Data,
    output logic [7:0] lapd3Data,
    output logic [7:0] dlSrcData [0:7]
);
    logic gap_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_q <= 1'b0;
            pcmValid <= 1'b0;
            pcmSlot <= 5'h1F;
            pcmIn <= 8'h00;
        end
        else if (run && !(slow && gap_q))
        begin
            gap_q <= 1'b1;
            pcmValid <= 1'b1;
            pcmSlot <= pcmSlot + 5'h01;
            pcmIn <= (rnd[31:30] == 2'h0) ? 8'h00 : rnd[7:0];
        end
        else
        begin
            gap_q <= 1'b0;
            pcmValid <= 1'b0;
            // idle lines must not keep showing the last octet
            pcmIn <= ~pcmIn;
        end
    end
    always_ff @(posedge clk)
    begin
        lapd1Data <= rnd[15:8];
        lapd2Data <= rnd[23:16];
        lapd3Data <= rnd[30:23];
        for (int i = 0; i < 8; i++) dlSrcData[i] <= rnd[i+:8] ^ 8'(i * 37);
    end
endmodule : tx_pcm_partner

// ---- tb_tx_timeslot_conditioning.sv ----
// self-checking bench for the timeslot conditioning block
`timescale 1ns/1ps
module tb_tx_timeslot_conditioning
    import tx_cond_pkg::*;
;
    typedef struct packed {
        logic chk;
        logic de;
        logic [4:0] slot;
        logic [7:0] data;
    } exp_t;
    logic clk, nrst, clkEn, run, slow, modeM, enD;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rnd, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic pcmValid, lineValid, lineDeSlot;
    logic [SLOT_W-1:0] pcmSlot, lineSlot;
    logic [7:0] pcmIn, lineData, lapd1, lapd2, lapd3, idleM;
    logic [7:0] dlSrc [0:7];
    logic [7:0] ctrlM [0:31];
    logic [2:0] selM;
    int errors, check_count, stall;
    exp_t e;
    exp_t expQ [$];
    tx_timeslot_conditioning tx_timeslot_conditioning_i (
        .clk(clk), .nrst(nrst), .clkEn(clkEn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .pcmValid(pcmValid), .pcmSlot(pcmSlot), .pcmIn(pcmIn),
        .lapd1Data(lapd1), .lapd2Data(lapd2), .lapd3Data(lapd3),
        .dlSrcData(dlSrc), .lineValid(lineValid), .lineSlot(lineSlot),
        .lineData(lineData), .lineDeSlot(lineDeSlot));
    tx_pcm_partner tx_pcm_partner_i (
        .clk(clk), .nrst(nrst), .run(run), .slow(slow), .rnd(rnd),
        .pcmValid(pcmValid), .pcmSlot(pcmSlot), .pcmIn(pcmIn),
        .lapd1Data(lapd1), .lapd2Data(lapd2), .lapd3Data(lapd3),
        .dlSrcData(dlSrc));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] nextRand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nextRand
    always @(posedge clk)
    begin
        seed = nextRand(seed);
        rnd <= seed;
    end
    task automatic check(input string what, input logic [31:0] ex, got);
        check_count++;
        if (got !== ex)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, ex, got);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        n = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'h1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= (n >= stall);
        end
        while (!(bvalid && bready) && n < 100);
        bready <= 1'b0;
        check("bresp", 32'(er), 32'(bresp));
    endtask : axiWrite
    task automatic rdChk(input logic [7:0] a, input logic [31:0] ex,
        input logic [1:0] er);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        do
        begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            rready <= (n >= stall);
        end
        while (!(rvalid && rready) && n < 100);
        rready <= 1'b0;
        check("rdata", ex, rdata);
        check("rresp", 32'(er), 32'(rresp));
    endtask : rdChk
    // ------------------------------------------------------------
    // reference model of the conditioned octet
    // ------------------------------------------------------------
    function automatic exp_t model(input logic [4:0] s, input logic [7:0] x);
        exp_t r;
        logic [7:0] c;
        c = ctrlM[s];
        r = {1'b1, 1'b0, s, x};
        case (c[COND_HI:COND_LO])
            C_INV_ALL: r.data = x ^ ALL_MASK;
            C_INV_EVEN: r.data = x ^ EVEN_MASK;
            C_INV_ODD: r.data = x ^ ODD_MASK;
            C_USER_IDLE: r.data = idleM;
            C_BUSY: r.data = BUSY_CODE;
            C_VACANT: r.data = VACANT_CODE;
            C_BUSY_TIMESLOT_CODE: r.data = x | busy_timeslot_code;
            C_MUX_OUT_OF_FRAME_CODE: r.data = mux_out_of_frame_code;
            C_INV_MSB: r.data = x ^ MSB_MASK;
            C_INV_LOW: r.data = x ^ LOW_MASK;
            // generator sequences: only slot and marker are compared
            C_MW_ALAW, C_MW_ULAW, C_PRBS: r.chk = 1'b0;
            C_DE_SLOT:
            begin
                r.de = 1'b1;
                case (c[LAPD_HI:LAPD_LO])
                    LAPD_FIRST: r.data = lapd1;
                    LAPD_SECOND: r.data = lapd2;
                    LAPD_THIRD: r.data = lapd3;
                    default: r.data = dlSrc[modeM ? selM : {1'b0, selM[1:0]}];
                endcase
            end
            default: r.data = x;
        endcase
        if (!modeM && !r.de && r.data == ZERO_OCTET)
            case (c[ZCS_HI:ZCS_LO])
                ZCS_BIT7: r.data = BIT7_FORCE;
                ZCS_ALT: r.data = ALT_ZCS_CODE;
                ZCS_DDS: r.data = DDS_ZCS_CODE;
                default: r.data = ZERO_OCTET;
            endcase
        return r;
    endfunction : model
    always @(posedge clk)
    begin
        if (nrst && clkEn && pcmValid)
            expQ.push_back(model(pcmSlot, pcmIn));
        if (nrst && enD && lineValid && expQ.size() == 0)
            check("lineValid", 32'h0, 32'h1);
        else if (nrst && enD && lineValid)
        begin
            e = expQ.pop_front();
            check("lineSlot", 32'(e.slot), 32'(lineSlot));
            check("lineDeSlot", 32'(e.de), 32'(lineDeSlot));
            if (e.chk) check("lineData", 32'(e.data), 32'(lineData));
        end
        enD = clkEn;
    end
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h0000AA02;
        {errors, check_count, stall} = '0;
        {nrst, run, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
        clkEn = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdChk(CHAN_CTRL_BASE, 32'(CHAN_CTRL_RESET), RESP_OKAY);
        rdChk(8'h7C, 32'(CHAN_CTRL_RESET), RESP_OKAY);
        rdChk(USER_IDLE_ADDR, 32'(USER_IDLE_RESET), RESP_OKAY);
        stall = 2;
        axiWrite(8'h8C, 32'h000000FF, RESP_SLVERR);
        rdChk(8'h8C, 32'h0, RESP_SLVERR);
        for (int rd = 0; rd < 8; rd++)
        begin
            modeM = rd[0];
            selM = rnd[2:0];
            idleM = rnd[15:8];
            axiWrite(MODE_ADDR, {31'h0, modeM}, RESP_OKAY);
            axiWrite(DL_SELECT_ADDR, {29'h0, selM}, RESP_OKAY);
            axiWrite(USER_IDLE_ADDR, {24'h0, idleM}, RESP_OKAY);
            rdChk(USER_IDLE_ADDR, {24'h0, idleM}, RESP_OKAY);
            for (int s = 0; s < 32; s++)
            begin
                ctrlM[s] = {rnd[7:4], 4'(s + rd)};
                axiWrite(8'(4 * s), {24'h0, ctrlM[s]}, RESP_OKAY);
            end
            rdChk(8'(4 * rd), {24'h0, ctrlM[rd]}, RESP_OKAY);
            stall = rd % 3;
            slow <= rd[1];
            run <= 1'b1;
            repeat (80)
            begin
                @(posedge clk);
                clkEn <= rnd[3] | !rd[2];
            end
            clkEn <= 1'b1;
            run <= 1'b0;
            repeat (4) @(posedge clk);
        end
        check("pending", 32'h0, 32'(expQ.size()));
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule : tb_tx_timeslot_conditioning
bind tx_timeslot_conditioning tx_cond_props tx_cond_props_i (.*);
